/* verilog/serial_port_regs.svh */
// Register map, field positions and counts of the four-mode serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define SP_IDX_CTRL     8'h98
`define SP_IDX_BUF      8'h99
`define SP_IDX_IRQ_ST   8'hb0
`define SP_IDX_IRQ_CLR  8'hb1
`define SP_IDX_IRQ_EN   8'hb2
`define SP_IDX_BAUD     8'hb3
`define SP_B_MODE_HI    7
`define SP_B_MODE_LO    6
`define SP_B_FILTER     5
`define SP_B_RX_EN      4
`define SP_B_TX9        3
`define SP_B_RX9        2
`define SP_B_TX_DONE    1
`define SP_B_RX_DONE    0
`define SP_B_SLOW       16
`define SP_IRQ_RX       0
`define SP_IRQ_TX       1
`define SP_MODE_SHIFT   2'b00
`define SP_MODE_FIXED   2'b10
`define SP_DIV_RST      16'h0040
`define SP_M2_FAST      16'h0001
`define SP_M2_SLOW      16'h0003
`define SP_OVS_MID      4'h7
`define SP_OVS_LAST     4'hf
`define SP_TX_BITS8     4'h9
`define SP_TX_BITS9     4'ha
`define SP_RX_BITS8     4'h8
`define SP_RX_BITS9     4'h9
`define SP_M0_TXBITS    4'h8
`define SP_M0_RXBITS    4'h9
`define SP_TX_NINE      9
`endif

/* verilog/serial_port_pkg.sv */
// Types shared by the serial port design files
package serial_port_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP  = 3'b100
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;
endpackage : serial_port_pkg

/* verilog/serial_sync2.sv */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module serial_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_o  <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule : serial_sync2

/* verilog/serial_baud_tick.sv */
// Reloadable down-counter giving one oversampling tick per period
`timescale 1ns/1ps
module serial_baud_tick #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic [DIV_W-1:0] reload_i,
  output logic                  tick_o
);
  logic [DIV_W-1:0] cnt_ff;
  if (DIV_W < 2) begin : g_chk
    $error("DIV_W must be at least 2");
  end
  assign tick_o = (cnt_ff == '0);
  // New reload value takes effect at the next tick, so no period is cut short
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (tick_o) begin
      cnt_ff <= reload_i;
    end else begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : serial_baud_tick

/* verilog/serial_port_four_mode.sv */
// Four-mode serial port with Avalon-MM register slave and interrupt
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_port_four_mode #(
  parameter logic [15:0] DIV_RST = `SP_DIV_RST
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [9:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic             irq_o,
  output logic             txd_o,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_n_o
);
  import serial_port_pkg::*;

  logic        ack_ff;
  logic [1:0]  mode_ff;
  logic        filter_ff, rx_en_ff, tx9_ff, rx9_ff, tx_done_ff, rx_done_ff;
  logic [7:0]  rx_buf_ff;
  logic [15:0] div_ff;
  logic        slow_ff;
  logic [1:0]  irq_st_ff, irq_en_ff;
  logic        rxd_s, baud_tick, txd_ff;
  logic [15:0] reload;
  tx_state_t   tx_st_ff;
  rx_state_t   rx_st_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0]  tx_cnt_ff, tx_os_ff, rx_cnt_ff, rx_os_ff, m0_cnt_ff;
  logic [8:0]  rx_sh_ff;
  logic        m0_busy_ff, m0_rx_ff, m0_ph_ff;
  logic [7:0]  m0_sh_ff;
  logic [31:0] nxt_rdata;

  wire       req     = read_i | write_i;
  wire [7:0] idx     = address_i[9:2];
  wire       wr_b0   = write_i & ack_ff & byteenable_i[0];
  wire       wr_ctl  = wr_b0 & (idx == `SP_IDX_CTRL);
  wire       wr_buf  = wr_b0 & (idx == `SP_IDX_BUF);
  wire       wr_clr  = wr_b0 & (idx == `SP_IDX_IRQ_CLR);
  wire       wr_en   = wr_b0 & (idx == `SP_IDX_IRQ_EN);
  wire       wr_baud = write_i & ack_ff & (idx == `SP_IDX_BAUD);
  wire       async   = (mode_ff != `SP_MODE_SHIFT);
  wire       nine    = mode_ff[`SP_B_MODE_HI - `SP_B_MODE_LO];
  wire       idle    = (tx_st_ff == TX_IDLE) & ~m0_busy_ff;
  wire       tx_go   = wr_buf & idle;
  wire       os_last = baud_tick & (tx_os_ff == `SP_OVS_LAST);
  wire       rx_mid  = baud_tick & (rx_os_ff == `SP_OVS_MID);
  wire       rx_end  = baud_tick & (rx_os_ff == `SP_OVS_LAST);
  wire       tx_set_a = (tx_st_ff == TX_SHIFT) & os_last & (tx_cnt_ff == 4'h1);
  wire       m0_end  = m0_busy_ff & m0_ph_ff & (m0_cnt_ff == 4'h1);
  wire [7:0] m0_data = {rxd_s, m0_sh_ff[7:1]};
  wire       rx_smp  = (rx_st_ff == RX_STOP) & rx_mid;
  // Ninth data bit in 9-bit modes, stop bit in the 8-bit mode
  wire       bit9    = nine ? rx_sh_ff[8] : rxd_s;
  // Filtering drops frames whose ninth or stop bit is zero; a full buffer is kept
  wire       rx_take = rx_smp & ~rx_done_ff & (~filter_ff | bit9);
  wire [7:0] rx_data = nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
  wire       tx_set  = tx_set_a | (m0_end & ~m0_rx_ff);
  wire       rx_set  = rx_take | (m0_end & m0_rx_ff);

  // Pin synchroniser and bit-rate tick
  serial_sync2 #(.RST_VAL(1'b1)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (rxd_i),
    .sync_o    (rxd_s)
  );
  // Fixed mode ticks every 2 or 4 clocks, giving 32 or 64 clocks per bit
  assign reload = (mode_ff == `SP_MODE_FIXED) ? (slow_ff ? `SP_M2_SLOW : `SP_M2_FAST)
                                              : div_ff;
  serial_baud_tick #(.DIV_W(16)) u_baud (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .reload_i  (reload),
    .tick_o    (baud_tick)
  );

  // One wait state so read data can come from a flop
  assign waitrequest_o = req & ~ack_ff;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read mux; the buffer returns received data only
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `SP_IDX_CTRL:   nxt_rdata[7:0] = {mode_ff, filter_ff, rx_en_ff, tx9_ff, rx9_ff,
                                        tx_done_ff, rx_done_ff};
      `SP_IDX_BUF:    nxt_rdata[7:0] = rx_buf_ff;
      `SP_IDX_IRQ_ST: nxt_rdata[1:0] = irq_st_ff;
      `SP_IDX_IRQ_EN: nxt_rdata[1:0] = irq_en_ff;
      `SP_IDX_BAUD:   nxt_rdata[16:0] = {slow_ff, div_ff};
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & ~ack_ff) begin
      readdata_o <= nxt_rdata;
    end
  end

  // Control bits; receive enable resets to 0
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_ff   <= 2'h0;
      filter_ff <= 1'b0;
      rx_en_ff  <= 1'b0;
      tx9_ff    <= 1'b0;
    end else if (wr_ctl) begin
      mode_ff   <= writedata_i[`SP_B_MODE_HI:`SP_B_MODE_LO];
      filter_ff <= writedata_i[`SP_B_FILTER];
      rx_en_ff  <= writedata_i[`SP_B_RX_EN];
      tx9_ff    <= writedata_i[`SP_B_TX9];
    end
  end

  // Flags: set by hardware or by a software write of 1; a hardware set in the clearing cycle wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_done_ff <= 1'b0;
      rx_done_ff <= 1'b0;
    end else if (wr_ctl) begin
      tx_done_ff <= writedata_i[`SP_B_TX_DONE] | tx_set;
      rx_done_ff <= writedata_i[`SP_B_RX_DONE] | rx_set;
    end else begin
      tx_done_ff <= tx_done_ff | tx_set;
      rx_done_ff <= rx_done_ff | rx_set;
    end
  end

  // Received byte and ninth bit; hardware load beats a software write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_buf_ff <= 8'h00;
      rx9_ff    <= 1'b0;
    end else if (rx_take) begin
      rx_buf_ff <= rx_data;
      rx9_ff    <= bit9;
    end else if (m0_end & m0_rx_ff) begin
      rx_buf_ff <= m0_data;
    end else if (wr_ctl) begin
      rx9_ff    <= writedata_i[`SP_B_RX9];
    end
  end

  // Baud divisor and fixed-mode rate select
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_ff  <= DIV_RST;
      slow_ff <= 1'b0;
    end else if (wr_baud) begin
      if (byteenable_i[0]) div_ff[7:0]  <= writedata_i[7:0];
      if (byteenable_i[1]) div_ff[15:8] <= writedata_i[15:8];
      if (byteenable_i[2]) slow_ff      <= writedata_i[`SP_B_SLOW];
    end
  end

  // Sticky interrupt status, write-one-to-clear, set wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_st_ff <= 2'h0;
      irq_en_ff <= 2'h0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~(wr_clr ? writedata_i[1:0] : 2'h0)) | {tx_set, rx_set};
      if (wr_en) irq_en_ff <= writedata_i[1:0];
    end
  end
  assign irq_o = |(irq_st_ff & irq_en_ff);

  // Async transmitter: start, 8 data, optional ninth, stop; 16 ticks per bit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_st_ff  <= TX_IDLE;
      tx_sh_ff  <= 11'h7ff;
      tx_cnt_ff <= 4'h0;
      tx_os_ff  <= 4'h0;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          tx_os_ff <= 4'h0;
          if (tx_go & async) begin
            tx_st_ff  <= TX_SHIFT;
            tx_sh_ff  <= {1'b1, nine ? tx9_ff : 1'b1, writedata_i[7:0], 1'b0};
            tx_cnt_ff <= nine ? `SP_TX_BITS9 : `SP_TX_BITS8;
          end
        end
        TX_SHIFT: begin
          if (baud_tick) tx_os_ff <= tx_os_ff + 4'h1;
          if (os_last) begin
            tx_sh_ff  <= {1'b1, tx_sh_ff[10:1]};
            tx_cnt_ff <= tx_cnt_ff - 4'h1;
            if (tx_cnt_ff == 4'h1) tx_st_ff <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (baud_tick) tx_os_ff <= tx_os_ff + 4'h1;
          if (os_last) tx_st_ff <= TX_IDLE;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Async receiver; false starts are dropped at mid start bit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_st_ff  <= RX_IDLE;
      rx_sh_ff  <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_os_ff  <= 4'h0;
    end else if (!rx_en_ff || !async) begin
      rx_st_ff <= RX_IDLE;
      rx_os_ff <= 4'h0;
    end else begin
      if (rx_st_ff != RX_IDLE && baud_tick) rx_os_ff <= rx_os_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          rx_os_ff <= 4'h0;
          if (baud_tick & ~rxd_s) rx_st_ff <= RX_START;
        end
        RX_START: begin
          if (rx_mid & rxd_s) rx_st_ff <= RX_IDLE;
          if (rx_end) begin
            rx_st_ff  <= RX_DATA;
            rx_cnt_ff <= nine ? `SP_RX_BITS9 : `SP_RX_BITS8;
          end
        end
        RX_DATA: begin
          if (rx_mid) rx_sh_ff <= {rxd_s, rx_sh_ff[8:1]};
          if (rx_end) begin
            rx_cnt_ff <= rx_cnt_ff - 4'h1;
            if (rx_cnt_ff == 4'h1) rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Shift register mode: bit = 2 clocks; receive discards the first sample since
  // the synchronised line lags by one bit, so a ninth period runs with clock high
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      m0_busy_ff <= 1'b0;
      m0_rx_ff   <= 1'b0;
      m0_ph_ff   <= 1'b0;
      m0_cnt_ff  <= 4'h0;
      m0_sh_ff   <= 8'hff;
    end else if (m0_busy_ff) begin
      m0_ph_ff <= ~m0_ph_ff;
      if (m0_ph_ff) begin
        m0_cnt_ff <= m0_cnt_ff - 4'h1;
        if (m0_rx_ff) begin
          if (m0_cnt_ff != `SP_M0_RXBITS) m0_sh_ff <= m0_data;
        end else begin
          m0_sh_ff <= {1'b1, m0_sh_ff[7:1]};
        end
        if (m0_cnt_ff == 4'h1) m0_busy_ff <= 1'b0;
      end
    end else if (tx_go & ~async) begin
      m0_busy_ff <= 1'b1;
      m0_rx_ff   <= 1'b0;
      m0_ph_ff   <= 1'b0;
      m0_cnt_ff  <= `SP_M0_TXBITS;
      m0_sh_ff   <= writedata_i[7:0];
    end else if (~async & rx_en_ff & ~rx_done_ff & ~wr_buf) begin
      m0_busy_ff <= 1'b1;
      m0_rx_ff   <= 1'b1;
      m0_ph_ff   <= 1'b0;
      m0_cnt_ff  <= `SP_M0_RXBITS;
    end
  end

  // Line outputs; in shift mode the transmit pin carries the shift clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      txd_ff <= 1'b1;
    end else if (~async) begin
      txd_ff <= ~m0_busy_ff | m0_ph_ff | (m0_rx_ff & (m0_cnt_ff == 4'h1));
    end else begin
      txd_ff <= (tx_st_ff == TX_SHIFT) ? tx_sh_ff[0] : 1'b1;
    end
  end
  assign txd_o      = txd_ff;
  assign rxd_o      = m0_sh_ff[0];
  assign rxd_oe_n_o = ~(m0_busy_ff & ~m0_rx_ff);

  // Checks
  sequence seq_fast;
    !baud_tick ##1 baud_tick;
  endsequence
  sequence seq_slow;
    !baud_tick [*3] ##1 baud_tick;
  endsequence
  AST_MODE2_FAST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    baud_tick && mode_ff == `SP_MODE_FIXED && !slow_ff |=> seq_fast)
    else $error("fixed rate /32 tick spacing wrong");
  AST_MODE2_SLOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    baud_tick && mode_ff == `SP_MODE_FIXED && slow_ff |=> seq_slow)
    else $error("fixed rate /64 tick spacing wrong");
  AST_TX_AT_STOP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_st_ff == TX_STOP && $past(tx_st_ff) == TX_SHIFT |-> tx_done_ff ##1 txd_ff [*2])
    else $error("transmit flag not set at stop start");
  AST_FLAG_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !wr_ctl && (tx_done_ff || rx_done_ff) |=> $past(tx_done_ff) <= tx_done_ff
      && $past(rx_done_ff) <= rx_done_ff)
    else $error("flag cleared by hardware");
  AST_RX_GATE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !rx_en_ff |=> rx_st_ff == RX_IDLE && !$rose(m0_rx_ff & m0_busy_ff))
    else $error("reception while disabled");
  AST_NINE_FILTER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_smp && nine && filter_ff && !rx_sh_ff[8] && !rx_done_ff && !wr_ctl |=> !rx_done_ff)
    else $error("filtered frame raised receive flag");
  AST_STOP_FILTER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_smp && !nine && filter_ff && !rxd_s && !rx_done_ff && !wr_ctl |=> !rx_done_ff)
    else $error("bad stop raised receive flag");
  AST_RX_LOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_take |=> rx_done_ff && rx_buf_ff == $past(rx_data) && rx9_ff == $past(bit9))
    else $error("received frame not stored");
  AST_TX_NINTH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_go && async && nine |=> tx_sh_ff[`SP_TX_NINE] == $past(tx9_ff) && tx_st_ff == TX_SHIFT)
    else $error("ninth transmit bit wrong");
  AST_M0_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_go && !async |=> m0_busy_ff [*8] ##9 !m0_busy_ff && tx_done_ff)
    else $error("shift mode frame length wrong");
endmodule : serial_port_four_mode

/* dv/serial_remote_node.sv */
// Remote serial node model: sends and captures asynchronous frames
`timescale 1ns/1ps
module serial_remote_node (
  input  wire logic clk_sys_i,
  input  wire logic line_i,
  output logic      line_o
);
  int         bit_clks = 32;
  logic [8:0] cap_data;
  logic       cap_stop;
  initial line_o = 1'b1;
  // Start low, bits LSB first, then line high; a zero top bit acts as a bad stop
  task automatic send(input logic [8:0] d, input int nbits);
    line_o <= 1'b0;
    repeat (bit_clks) @(posedge clk_sys_i);
    for (int i = 0; i < nbits; i++) begin
      line_o <= d[i];
      repeat (bit_clks) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
    repeat (bit_clks * 3) @(posedge clk_sys_i);
  endtask : send
  // Mid-bit sampling, so a wrong bit period corrupts the data
  task automatic capture(input int nbits);
    int n;
    n = 0;
    cap_data = '0;
    while (line_i !== 1'b0 && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (bit_clks / 2) @(posedge clk_sys_i);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk_sys_i);
      cap_data[i] = line_i;
    end
    repeat (bit_clks) @(posedge clk_sys_i);
    cap_stop = line_i;
  endtask : capture
  // Shift mode: new bit on each falling shift clock, held through the high phase
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_i);
      line_o <= d[i];
    end
    repeat (4) @(posedge clk_sys_i);
    line_o <= 1'b1;
  endtask : shift_in
endmodule : serial_remote_node

/* dv/test_serial_port_four_mode.sv */
// Self-checking testbench of the four-mode serial port
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module test_serial_port_four_mode;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [9:0]  address_i = '0;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = '0;
  logic [31:0] readdata_o;
  logic        waitrequest_o, irq_o, txd_o, rxd_o, rxd_oe_n_o;
  logic        node_line, rxd_i;
  int          n_errors = 0;
  int          compares = 0;
  logic [7:0]  sh;

  always #50 clk_sys_i = ~clk_sys_i;
  // Data pin level: the port drives it only in shift-register transmit
  assign rxd_i = rxd_oe_n_o ? node_line : rxd_o;

  serial_port_four_mode #(.DIV_RST(16'h0001)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
    .txd_o(txd_o), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o));
  serial_remote_node i_node (.clk_sys_i(clk_sys_i), .line_i(txd_o), .line_o(node_line));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One bus access; request held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address_i   <= {idx, 2'b00};
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= !wr;
    @(posedge clk_sys_i);
    while (waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 20) n_errors++;
    q = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
    @(posedge clk_sys_i);
  endtask : acc
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, idx, 32'h0, q);
    check(what, exp, q);
  endtask : rd
  // Poll the control register until the receive flag shows
  task automatic wait_rx();
    logic [31:0] q;
    q = '0;
    for (int i = 0; i < 200 && q[`SP_B_RX_DONE] !== 1'b1; i++) acc(1'b0, `SP_IDX_CTRL, 0, q);
  endtask : wait_rx
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (50000) @(posedge clk_sys_i);
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // Reset values, unmapped place
    rd("ctrl", `SP_IDX_CTRL, 32'h0);
    rd("irq_st", `SP_IDX_IRQ_ST, 32'h0);
    wr(8'h10, 32'hff);
    rd("unmapped", 8'h10, 32'h0);
    check("idle_line", 1, txd_o);
    $display("test reset done");
    // Nine-bit variable rate transmit carries the control ninth bit
    wr(`SP_IDX_BAUD, 32'h1);
    wr(`SP_IDX_CTRL, 32'hc8);
    fork
      i_node.capture(9);
      wr(`SP_IDX_BUF, 32'ha5);
    join
    check("tx9_frame", 9'h1a5, i_node.cap_data);
    check("tx9_stop", 1, i_node.cap_stop);
    rd("ctrl", `SP_IDX_CTRL, 32'hca);
    rd("irq_st", `SP_IDX_IRQ_ST, 32'h2);
    wr(`SP_IDX_IRQ_CLR, 32'h3);
    repeat (100) @(posedge clk_sys_i);
    rd("ctrl", `SP_IDX_CTRL, 32'hca);
    $display("test tx mode 11 done");
    // Fixed rate at both divisors; a zero ninth bit goes out too
    for (int s = 0; s < 2; s++) begin
      wr(`SP_IDX_BAUD, {15'h0, s[0], 16'h1});
      i_node.bit_clks = 32 * (s + 1);
      wr(`SP_IDX_CTRL, 32'h80);
      fork
        i_node.capture(9);
        wr(`SP_IDX_BUF, 32'h96);
      join
      check("tx_fixed", 9'h096, i_node.cap_data);
      repeat (64) @(posedge clk_sys_i); // A write during the stop bit would be ignored
    end
    $display("test tx mode 10 done");
    // Eight-bit receive, stop bit into the ninth-bit field, interrupt
    i_node.bit_clks = 32;
    wr(`SP_IDX_BAUD, 32'h1);
    wr(`SP_IDX_IRQ_EN, 32'h1);
    wr(`SP_IDX_CTRL, 32'h50);
    i_node.send(9'h03c, 8);
    wait_rx();
    rd("ctrl", `SP_IDX_CTRL, 32'h55);
    rd("buf", `SP_IDX_BUF, 32'h3c);
    check("irq_on", 1, irq_o);
    wr(`SP_IDX_IRQ_CLR, 32'h1);
    check("irq_off", 0, irq_o);
    // Filter on: a bad stop bit raises no flag
    wr(`SP_IDX_CTRL, 32'h70);
    i_node.send(9'h0aa, 9);
    rd("ctrl", `SP_IDX_CTRL, 32'h70);
    // Reception disabled
    wr(`SP_IDX_CTRL, 32'h40);
    i_node.send(9'h011, 8);
    rd("ctrl", `SP_IDX_CTRL, 32'h40);
    $display("test rx mode 01 done");
    // Nine-bit filtering, interrupt masked
    wr(`SP_IDX_IRQ_EN, 32'h0);
    wr(`SP_IDX_CTRL, 32'hf0);
    i_node.send(9'h0c3, 9);
    rd("ctrl", `SP_IDX_CTRL, 32'hf0);
    i_node.send(9'h1c3, 9);
    wait_rx();
    rd("ctrl", `SP_IDX_CTRL, 32'hf5);
    rd("buf", `SP_IDX_BUF, 32'hc3);
    rd("irq_st", `SP_IDX_IRQ_ST, 32'h3);
    check("irq_masked", 0, irq_o);
    $display("test rx mode 11 done");
    // Shift register transmit: data as it stood just before each rising shift clock
    wr(`SP_IDX_CTRL, 32'h00);
    fork
      begin : shift_cap
        int k, n, last;
        logic prev, prev_d, prev_oe;
        k = 0;
        n = 0;
        last = 0;
        prev = 1'b1;
        prev_d = 1'b1;
        prev_oe = 1'b1;
        while (k < 8 && n < 300) begin
          @(posedge clk_sys_i);
          n++;
          if (txd_o === 1'b1 && prev === 1'b0) begin
            sh[k] = prev_d;
            check("pin_driven", 0, prev_oe);
            if (k > 0) check("shift_period", 2, n - last);
            last = n;
            k++;
          end
          prev = txd_o;
          prev_d = rxd_o;
          prev_oe = rxd_oe_n_o;
        end
      end
      wr(`SP_IDX_BUF, 32'h5a);
    join
    check("shift_data", 8'h5a, sh);
    repeat (10) @(posedge clk_sys_i);
    rd("ctrl", `SP_IDX_CTRL, 32'h02);
    // Shift register receive starts by itself once enabled
    fork
      i_node.shift_in(8'hc6);
      wr(`SP_IDX_CTRL, 32'h10);
    join
    rd("ctrl", `SP_IDX_CTRL, 32'h11);
    rd("buf", `SP_IDX_BUF, 32'hc6);
    $display("test mode 00 done");
    end_of_test();
  end
endmodule : test_serial_port_four_mode
